// File: men_concentrator.sv
// concentrator model facing the notifier's radio side
`timescale 1ns/1ps
`default_nettype none
module men_concentrator
  import men_pkg::*;
(
  input wire logic ref_clk_i,
  input wire men_tx_t tx_req_i,
  input wire logic mute_i,
  input wire logic dl_i,
  output logic tx_ready_o,
  output logic ack_o,
  output logic ack_dl_o
);
  int wait_cnt = 0;
  initial begin
    tx_ready_o = 1'b0;
    ack_o = 1'b0;
    ack_dl_o = 1'b0;
  end
  // take each request at once, answer four cycles later; mute models a lost link
  always @(negedge ref_clk_i) begin
    tx_ready_o <= tx_req_i.valid && !tx_ready_o;
    ack_o <= !mute_i && wait_cnt == 1;
    ack_dl_o <= (wait_cnt == 1) ? dl_i : ~ack_dl_o;
    wait_cnt <= tx_ready_o ? 3 : (wait_cnt > 0 ? wait_cnt - 1 : 0);
  end
endmodule
`default_nettype wire

// File: men_consts.svh
// constants of the motion event notifier: timing figures and counts
`ifndef MEN_CONSTS_SVH
`define MEN_CONSTS_SVH
// all timing figures are sized to the counter width so the products never wrap
`define MEN_CLK_HZ 38'h2FAF080
`define MEN_SEC_PER_MIN 38'h3C
`define MEN_MS_PER_S 38'h3E8
`define MEN_KA_PERIOD_MIN 38'h1E
`define MEN_KA_CYCLES (`MEN_KA_PERIOD_MIN * `MEN_SEC_PER_MIN * `MEN_CLK_HZ)
`define MEN_WAIT_WIN_S 38'h3C
`define MEN_WAIT_CYCLES (`MEN_WAIT_WIN_S * `MEN_CLK_HZ)
`define MEN_ACK_TIMEOUT_MS 38'h14
`define MEN_ACK_CYCLES (`MEN_ACK_TIMEOUT_MS * (`MEN_CLK_HZ / `MEN_MS_PER_S))
`define MEN_MAX_RETRY 2'h3
`define MEN_TRY_ONE 2'h1
// failure count at which the next timeout gives up
`define MEN_TRY_LAST (`MEN_MAX_RETRY - `MEN_TRY_ONE)
`define MEN_CNT_W 38
`define MEN_TRY_W 2
`define MEN_TRY_ZERO 2'h0
`define MEN_CNT_ZERO 38'h0
`define MEN_CNT_ONE 38'h1
`endif

// File: men_notifier.sv
// motion event notifier: notification, keep-alive, ack/retry and loss sequencer
// Summary of operation
// - a motion interrupt outside an open wait window starts a motion notification.
// - a keep-alive is sent every 30 minutes regardless of motion.
// - after each send, wait for acknowledge; resend the same message if none.
// - at most 2 retries; three consecutive failures raise the lost-network LED.
// - after loss, try again at the next keep-alive or motion event.
// - after a motion interrupt stay in standby with a wait window open.
// - wait window lasts 60 s; interrupts inside it join the same event.
// - interrupts closer than the window never yield another motion notification.
// - keep-alive during merging carries a multiple-interrupts indication.
`timescale 1ns/1ps
`default_nettype none
`include "men_consts.svh"
module men_notifier
  import men_pkg::*;
#(
  parameter logic [`MEN_CNT_W-1:0] KA_CYCLES = `MEN_KA_CYCLES,
  parameter logic [`MEN_CNT_W-1:0] WAIT_CYCLES = `MEN_WAIT_CYCLES,
  parameter logic [`MEN_CNT_W-1:0] ACK_CYCLES = `MEN_ACK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic motion_irq_i,
  input wire logic tx_ready_i,
  input wire logic ack_i,
  input wire logic ack_downlink_i,
  output var men_tx_t tx_req_o,
  output logic standby_o,
  output logic lost_network_o,
  output logic downlink_pending_o
);

  men_state_t state_reg, state_next;
  men_msg_t msg_reg, msg_next;
  logic [`MEN_CNT_W-1:0] ka_cnt_reg, ka_cnt_next;
  logic [`MEN_CNT_W-1:0] win_cnt_reg, win_cnt_next;
  logic [`MEN_CNT_W-1:0] ack_cnt_reg, ack_cnt_next;
  logic [`MEN_TRY_W-1:0] fail_reg, fail_next;
  logic win_open_reg, win_open_next;
  logic multi_reg, multi_next;
  logic motion_pend_reg, motion_pend_next;
  logic ka_pend_reg, ka_pend_next;
  logic retry_reg, retry_next;
  logic lost_reg, lost_next;
  logic dl_reg, dl_next;
  logic ka_tick;
  logic new_event;

  // down-counter helper shared by all timers
  function automatic logic [`MEN_CNT_W-1:0] men_dec(input logic [`MEN_CNT_W-1:0] v);
    men_dec = (v == `MEN_CNT_ZERO) ? `MEN_CNT_ZERO : v - `MEN_CNT_ONE;
  endfunction

  assign ka_tick = (ka_cnt_reg == `MEN_CNT_ONE);
  assign new_event = motion_irq_i && !win_open_reg;

  // timers, event capture and the send / ack sequencer
  always_comb begin
    state_next = state_reg;
    msg_next = msg_reg;
    fail_next = fail_reg;
    retry_next = retry_reg;
    lost_next = lost_reg;
    dl_next = dl_reg;
    ack_cnt_next = men_dec(ack_cnt_reg);
    // free-running keep-alive period, reloaded on expiry
    ka_cnt_next = ka_tick ? KA_CYCLES : men_dec(ka_cnt_reg);
    ka_pend_next = ka_pend_reg || ka_tick;
    // window restarts on every interrupt, so a busy area stays one event
    win_open_next = win_open_reg;
    win_cnt_next = men_dec(win_cnt_reg);
    multi_next = multi_reg;
    if (motion_irq_i) begin
      win_open_next = 1'b1;
      win_cnt_next = WAIT_CYCLES;
      if (win_open_reg) begin
        multi_next = 1'b1;
      end
    end else if (win_open_reg && win_cnt_reg == `MEN_CNT_ONE) begin
      win_open_next = 1'b0;
      multi_next = 1'b0;
    end
    motion_pend_next = motion_pend_reg || new_event;
    case (state_reg)
      MEN_IDLE: begin
        // motion has priority; a pending keep-alive follows it
        if (motion_pend_reg) begin
          msg_next = MEN_MSG_MOTION;
          motion_pend_next = new_event;
          retry_next = 1'b0;
          state_next = MEN_SEND;
        end else if (ka_pend_reg) begin
          msg_next = multi_reg ? MEN_MSG_KEEPALIVE_MULTI : MEN_MSG_KEEPALIVE;
          ka_pend_next = ka_tick;
          retry_next = 1'b0;
          state_next = MEN_SEND;
        end
      end
      MEN_SEND: begin
        if (tx_ready_i) begin
          ack_cnt_next = ACK_CYCLES;
          state_next = MEN_WAIT_ACK;
        end
      end
      MEN_WAIT_ACK: begin
        if (ack_i) begin
          fail_next = `MEN_TRY_ZERO;
          lost_next = 1'b0;
          dl_next = ack_downlink_i && msg_reg != MEN_MSG_MOTION;
          state_next = MEN_IDLE;
        end else if (ack_cnt_reg == `MEN_CNT_ONE) begin
          if (fail_reg == `MEN_TRY_LAST) begin
            // third consecutive failure: give up until the next trigger
            fail_next = `MEN_TRY_ZERO;
            lost_next = 1'b1;
            state_next = MEN_IDLE;
          end else begin
            fail_next = fail_reg + `MEN_TRY_ONE;
            retry_next = 1'b1;
            state_next = MEN_SEND;
          end
        end
      end
      default: begin
        state_next = MEN_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= MEN_IDLE;
      msg_reg <= MEN_MSG_KEEPALIVE;
      ka_cnt_reg <= KA_CYCLES;
      win_cnt_reg <= `MEN_CNT_ZERO;
      ack_cnt_reg <= `MEN_CNT_ZERO;
      fail_reg <= `MEN_TRY_ZERO;
      win_open_reg <= 1'b0;
      multi_reg <= 1'b0;
      motion_pend_reg <= 1'b0;
      ka_pend_reg <= 1'b0;
      retry_reg <= 1'b0;
      lost_reg <= 1'b0;
      dl_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      msg_reg <= msg_next;
      ka_cnt_reg <= ka_cnt_next;
      win_cnt_reg <= win_cnt_next;
      ack_cnt_reg <= ack_cnt_next;
      fail_reg <= fail_next;
      win_open_reg <= win_open_next;
      multi_reg <= multi_next;
      motion_pend_reg <= motion_pend_next;
      ka_pend_reg <= ka_pend_next;
      retry_reg <= retry_next;
      lost_reg <= lost_next;
      dl_reg <= dl_next;
    end
  end

  // request is a handshake output; kind comes from a flop
  // one process drives the whole struct so no field has a second driver
  always_comb begin
    tx_req_o.valid = (state_reg == MEN_SEND);
    tx_req_o.retry = retry_reg;
    tx_req_o.kind = msg_reg;
  end
  assign standby_o = win_open_reg;
  assign lost_network_o = lost_reg;
  assign downlink_pending_o = dl_reg;

  sequence men_send_done_s;
    tx_req_o.valid && tx_ready_i;
  endsequence

  sequence men_wait_timeout_s;
    (state_reg == MEN_WAIT_ACK && !ack_i && ack_cnt_reg == `MEN_CNT_ONE && fail_reg != `MEN_TRY_LAST);
  endsequence

  merged_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    win_open_reg && motion_irq_i |=> !motion_pend_reg || $past(motion_pend_reg))
    else $error("merged interrupt raised a new motion notification");
  new_event_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    new_event |=> motion_pend_reg || state_reg == MEN_SEND)
    else $error("motion event not queued");
  window_open_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    motion_irq_i |=> standby_o)
    else $error("standby window not opened");
  window_reload_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    motion_irq_i |=> win_cnt_reg == WAIT_CYCLES)
    else $error("wait window not restarted");
  ack_wait_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    men_send_done_s |=> state_reg == MEN_WAIT_ACK && ack_cnt_reg == ACK_CYCLES)
    else $error("no ack wait after send");
  resend_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    men_wait_timeout_s |=> tx_req_o.valid && tx_req_o.retry && tx_req_o.kind == $past(msg_reg))
    else $error("message not resent after timeout");
  lost_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == MEN_WAIT_ACK && !ack_i && ack_cnt_reg == `MEN_CNT_ONE && fail_reg == `MEN_TRY_LAST
    |=> lost_network_o && state_reg == MEN_IDLE)
    else $error("lost network not flagged after three failures");
  ack_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == MEN_WAIT_ACK && ack_i |=> !lost_network_o && fail_reg == `MEN_TRY_ZERO)
    else $error("ack did not clear failure state");
  ka_pend_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ka_tick |=> ka_pend_reg && ka_cnt_reg == KA_CYCLES)
    else $error("keep-alive period not honoured");
  ka_multi_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == MEN_IDLE && !motion_pend_reg && ka_pend_reg && multi_reg
    |=> tx_req_o.kind == MEN_MSG_KEEPALIVE_MULTI)
    else $error("keep-alive lacks multi-interrupt indication");
  // a lost link must not block the next trigger from going out fresh
  lost_retry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    lost_network_o && state_reg == MEN_IDLE && (motion_pend_reg || ka_pend_reg)
    |=> tx_req_o.valid && !tx_req_o.retry)
    else $error("no new attempt after network loss");
  window_close_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    win_open_reg && !motion_irq_i && win_cnt_reg == `MEN_CNT_ONE |=> !standby_o && !multi_reg)
    else $error("wait window did not close on expiry");
  retry_cap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fail_reg <= `MEN_TRY_LAST)
    else $error("failure count beyond retry limit");
endmodule
`default_nettype wire

// File: men_pkg.sv
// types of the motion event notifier
`default_nettype none
package men_pkg;
  typedef enum logic [1:0] {
    MEN_MSG_MOTION,
    MEN_MSG_KEEPALIVE,
    MEN_MSG_KEEPALIVE_MULTI
  } men_msg_t;
  // one message request towards the radio
  typedef struct packed {
    logic valid;
    logic retry;
    men_msg_t kind;
  } men_tx_t;
  typedef enum {
    MEN_IDLE,
    MEN_SEND,
    MEN_WAIT_ACK
  } men_state_t;
endpackage
`default_nettype wire

// File: tb.sv
// self-checking testbench of the motion event notifier
`timescale 1ns/1ps
`default_nettype none
module tb;
  import men_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic irq = 1'b0;
  logic mute = 1'b0;
  logic dl = 1'b0;
  logic rdy, ack, ack_dl, standby, lost, dl_pend;
  men_tx_t tx_req;
  int err_total = 0;
  int n_tests = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  // short counts: keep-alive 200, window 50, ack timeout 10 cycles
  men_notifier #(.KA_CYCLES(38'hC8), .WAIT_CYCLES(38'h32), .ACK_CYCLES(38'hA)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .motion_irq_i(irq), .tx_ready_i(rdy),
    .ack_i(ack), .ack_downlink_i(ack_dl), .tx_req_o(tx_req), .standby_o(standby),
    .lost_network_o(lost), .downlink_pending_o(dl_pend));
  men_concentrator peer (.ref_clk_i(ref_clk_i), .tx_req_i(tx_req), .mute_i(mute),
    .dl_i(dl), .tx_ready_o(rdy), .ack_o(ack), .ack_dl_o(ack_dl));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for the next request, judge it, let the peer take it
  task automatic take(input men_msg_t kind, input logic retry);
    int n;
    n = 0;
    while (tx_req.valid !== 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(8'(tx_req.valid), 8'h01);
    check(8'(tx_req.kind), 8'(kind));
    check(8'(tx_req.retry), 8'(retry));
    @(negedge ref_clk_i);
  endtask
  task automatic pulse;
    irq = 1'b1;
    @(negedge ref_clk_i);
    irq = 1'b0;
  endtask
  // outputs right after reset release, before any trigger
  task automatic sc_reset;
    check(8'(tx_req.valid), 8'h00);
    check(8'(tx_req.kind), 8'(MEN_MSG_KEEPALIVE));
    check(8'(standby), 8'h00);
    check(8'(lost), 8'h00);
    check(8'(dl_pend), 8'h00);
  endtask
  task automatic sc_ka;
    take(MEN_MSG_KEEPALIVE, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    check(8'(dl_pend), 8'h00);
  endtask
  // silent peer: first send plus two resends, then the led
  task automatic sc_loss;
    mute = 1'b1;
    pulse();
    check(8'(standby), 8'h01);
    take(MEN_MSG_MOTION, 1'b0);
    take(MEN_MSG_MOTION, 1'b1);
    check(8'(lost), 8'h00);
    take(MEN_MSG_MOTION, 1'b1);
    repeat (14) @(negedge ref_clk_i);
    check(8'(lost), 8'h01);
    check(8'(tx_req.valid), 8'h00);
  endtask
  task automatic sc_recover;
    mute = 1'b0;
    dl = 1'b1;
    take(MEN_MSG_KEEPALIVE, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    check(8'(lost), 8'h00);
    check(8'(dl_pend), 8'h01);
    dl = 1'b0;
  endtask
  // a burst longer than the keep-alive period, pulses closer than the window
  task automatic sc_merge;
    int multi;
    multi = 0;
    pulse();
    take(MEN_MSG_MOTION, 1'b0);
    for (int i = 0; i < 12; i++) begin
      pulse();
      repeat (29) begin
        if (tx_req.valid === 1'b1) begin
          check(8'(tx_req.kind), 8'(MEN_MSG_KEEPALIVE_MULTI));
          multi++;
        end
        @(negedge ref_clk_i);
      end
      check(8'(standby), 8'h01);
    end
    check(8'(multi > 0), 8'h01);
    check(8'(dl_pend), 8'h00);
    repeat (60) @(negedge ref_clk_i);
    check(8'(standby), 8'h00);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    sc_reset();
    sc_ka();
    sc_loss();
    sc_recover();
    sc_merge();
    complete_run();
  end
  // the sequence needs about 1000 cycles; five times that means a hang
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
